// >>> hw/lut_dac_cfg.svh
// Register offsets, field positions, reset values and counts of the converter source selector
`ifndef LUT_DAC_CFG_SVH
`define LUT_DAC_CFG_SVH
// Register indices; APB byte address is four times the index
`define IDX_CTRL0 10'h080
`define IDX_CTRL1 10'h081
`define IDX_CTRL2 10'h082
`define IDX_CTRL3 10'h083
`define IDX_CTRL4 10'h084
`define IDX_CTRL5 10'h085
`define IDX_WEN 10'h086
`define IDX_RESULT 10'h087
`define IDX_FIRST_LOOKUP_TABLE_BASE 10'h090
`define IDX_SECOND_LOOKUP_TABLE_BASE 10'h0D0
`define LUT_ROWS 64
// Field positions
`define BIT_REF_SEL 0
`define BIT_ADC_IN_SEL 1
`define BIT_FILT_DIS 2
`define BIT_L1_SEL 4
`define BIT_D1_SEL 5
`define BIT_L2_SEL 6
`define BIT_D2_SEL 7
`define BIT_WEL 7
// Write-enable patterns and reset values
`define WEN_SET 8'h80
`define WEN_CLR 8'h00
`define CTRL_RST 8'h00
`define CODE_IDLE 8'h00
// Consecutive conversions with equal upper six bits needed by the result filter
`define FILT_MATCHES 4
`endif

// >>> hw/lut_dac_pkg.sv
// Types shared by the converter source selector
package lut_dac_pkg;
	typedef struct packed {
		logic dac2_direct_sel;
		logic second_lookup_table_row_source_sel;
		logic dac1_direct_sel;
		logic first_lookup_table_row_source_sel;
		logic [3:0] full_scale;
	} select_type;
	typedef struct packed {
		logic reference_select;
		logic adc_input_select;
		logic adc_filter_disable;
	} analog_ctrl_type;
	typedef enum logic [1:0] {
		ST_RECALL,
		ST_WAIT_ADC,
		ST_RUN
	} phase_type;
endpackage : lut_dac_pkg

// >>> hw/lut_dac_source_select.sv
// Converter source selector: lookup tables, result filter, write-enable latch, APB registers
//
// Summary of operation
// - Table 1 row from result or manual bits
// - Converter 1 gets table byte or direct code
// - Table 2 row from result or manual bits
// - Converter 2 gets table byte or direct code
// - Writes refused while write latch clear, except to write register
// - Write latch volatile, clear after power-up
// - Writing 80h to write register sets latch
// - Latch holds until reset or 00h written
// - Latch write leaves other bits unchanged
// - Write-enable register at 86h
// - Read-only converter result at 87h
// - Result binary, 00h to FFh
// - Filter: four matching upper-six-bit conversions
// - Result upper six bits index tables
// - Manual rows from registers 1 and 2
// - Two 64-byte tables at 90h and D0h
// - Reference select, internal default
// - Converter input select, sensor default
// - Select bits live in register 5
// - Converter bytes 00h until result valid
`timescale 1ns/1ns
`include "lut_dac_cfg.svh"

module lut_dac_source_select
	import lut_dac_pkg::*;
#(
	parameter int ROWS = `LUT_ROWS
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic conv_valid,
	input wire logic [7:0] conv_data,
	output logic [7:0] dac1_code,
	output logic [7:0] dac2_code,
	output logic reference_select,
	output logic adc_input_select,
	output logic [3:0] full_scale_sel,
	output logic write_enable_latch
);

	// ****************************************
	// Decode
	// ****************************************
	function automatic logic in_table(input logic [9:0] idx, input logic [9:0] base);
		in_table = (idx >= base) && (idx < base + 10'(ROWS));
	endfunction : in_table

	logic [9:0] idx;
	logic setup;
	logic access;
	logic hit_first_lookup_table;
	logic hit_second_lookup_table;
	logic mapped;
	logic wr_ok;
	logic wr_bad;
	logic [5:0] first_lookup_table_off;
	logic [5:0] second_lookup_table_off;

	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign hit_first_lookup_table = in_table(idx, `IDX_FIRST_LOOKUP_TABLE_BASE);
	assign hit_second_lookup_table = in_table(idx, `IDX_SECOND_LOOKUP_TABLE_BASE);
	assign first_lookup_table_off = 6'(idx - `IDX_FIRST_LOOKUP_TABLE_BASE);
	assign second_lookup_table_off = 6'(idx - `IDX_SECOND_LOOKUP_TABLE_BASE);
	assign mapped = hit_first_lookup_table || hit_second_lookup_table || (idx >= `IDX_CTRL0 && idx <= `IDX_RESULT);
	// write refused while latch clear; the write register stays open
	assign wr_bad = pwrite && (!mapped || idx == `IDX_RESULT || (!write_enable_latch && idx != `IDX_WEN));
	assign wr_ok = access && pwrite && !wr_bad;
	assign pready = penable;
	assign pslverr = access && (wr_bad || !mapped);

	// ****************************************
	// Control registers
	// ****************************************
	analog_ctrl_type actl_q;
	analog_ctrl_type actl_d;
	select_type sel_q;
	select_type sel_d;
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl1_d;
	logic [7:0] ctrl2_q;
	logic [7:0] ctrl2_d;
	logic [7:0] ctrl3_q;
	logic [7:0] ctrl3_d;
	logic [7:0] ctrl4_q;
	logic [7:0] ctrl4_d;
	logic wel_q;
	logic wel_d;
	logic [7:0] wbyte;

	assign wbyte = pwdata[7:0];

	always_comb begin
		actl_d = actl_q;
		sel_d = sel_q;
		ctrl1_d = ctrl1_q;
		ctrl2_d = ctrl2_q;
		ctrl3_d = ctrl3_q;
		ctrl4_d = ctrl4_q;
		wel_d = wel_q;
		if (wr_ok) begin
			case (idx)
				`IDX_CTRL0: begin
					actl_d.reference_select = wbyte[`BIT_REF_SEL];
					actl_d.adc_input_select = wbyte[`BIT_ADC_IN_SEL];
					actl_d.adc_filter_disable = wbyte[`BIT_FILT_DIS];
				end
				`IDX_CTRL1: ctrl1_d = wbyte;
				`IDX_CTRL2: ctrl2_d = wbyte;
				`IDX_CTRL3: ctrl3_d = wbyte;
				`IDX_CTRL4: ctrl4_d = wbyte;
				`IDX_CTRL5: sel_d = select_type'(wbyte);
				`IDX_WEN: begin
					// only the two patterns move the latch
					if (wbyte == `WEN_SET) begin
						wel_d = 1'b1;
					end else if (wbyte == `WEN_CLR) begin
						wel_d = 1'b0;
					end
				end
				default: wel_d = wel_q;
			endcase
		end
	end

	// volatile copies take their stored defaults at power-on
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			actl_q <= analog_ctrl_type'(3'h0);
			sel_q <= select_type'(`CTRL_RST);
			ctrl1_q <= `CTRL_RST;
			ctrl2_q <= `CTRL_RST;
			ctrl3_q <= `CTRL_RST;
			ctrl4_q <= `CTRL_RST;
			wel_q <= 1'b0;
		end else begin
			actl_q <= actl_d;
			sel_q <= sel_d;
			ctrl1_q <= ctrl1_d;
			ctrl2_q <= ctrl2_d;
			ctrl3_q <= ctrl3_d;
			ctrl4_q <= ctrl4_d;
			wel_q <= wel_d;
		end
	end

	assign write_enable_latch = wel_q;
	// analog selects, zero picks the internal source
	assign reference_select = actl_q.reference_select;
	assign adc_input_select = actl_q.adc_input_select;
	assign full_scale_sel = sel_q.full_scale;

	// ****************************************
	// Lookup tables
	// ****************************************
	// Tables have no reset; contents are only defined once software loads them
	logic [7:0] first_lookup_table_mem [ROWS];
	logic [7:0] second_lookup_table_mem [ROWS];

	always_ff @(posedge clk_sys) begin
		if (wr_ok && hit_first_lookup_table) begin
			first_lookup_table_mem[first_lookup_table_off] <= wbyte;
		end
		if (wr_ok && hit_second_lookup_table) begin
			second_lookup_table_mem[second_lookup_table_off] <= wbyte;
		end
	end

	// ****************************************
	// Result filter
	// ****************************************
	logic [7:0] result_q;
	logic [7:0] result_d;
	logic [5:0] prev_q;
	logic [5:0] prev_d;
	logic [1:0] match_q;
	logic [1:0] match_d;
	logic have_prev_q;
	logic have_prev_d;
	logic update;
	logic same;
	assign same = have_prev_q && (conv_data[7:2] == prev_q);

	always_comb begin
		result_d = result_q;
		prev_d = prev_q;
		match_d = match_q;
		have_prev_d = have_prev_q;
		update = 1'b0;
		if (conv_valid) begin
			prev_d = conv_data[7:2];
			have_prev_d = 1'b1;
			// restart the run on a mismatch
			if (!same) begin
				match_d = 2'h0;
			end else if (match_q != 2'(`FILT_MATCHES - 1)) begin
				match_d = match_q + 2'h1;
			end
			update = actl_q.adc_filter_disable || (same && match_q >= 2'(`FILT_MATCHES - 2));
			if (update) begin
				result_d = conv_data;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			result_q <= 8'h00;
			prev_q <= 6'h00;
			match_q <= 2'h0;
			have_prev_q <= 1'b0;
		end else begin
			result_q <= result_d;
			prev_q <= prev_d;
			match_q <= match_d;
			have_prev_q <= have_prev_d;
		end
	end

	// ****************************************
	// Power-up sequence and converter bytes
	// ****************************************
	phase_type phase_q;
	phase_type phase_d;
	logic [7:0] dac1_q;
	logic [7:0] dac1_d;
	logic [7:0] dac2_q;
	logic [7:0] dac2_d;
	logic [5:0] row1;
	logic [5:0] row2;

	assign row1 = sel_q.first_lookup_table_row_source_sel ? ctrl1_q[5:0] : result_q[7:2];
	assign row2 = sel_q.second_lookup_table_row_source_sel ? ctrl2_q[5:0] : result_q[7:2];

	always_comb begin
		phase_d = phase_q;
		dac1_d = `CODE_IDLE;
		dac2_d = `CODE_IDLE;
		case (phase_q)
			// one cycle for the recall before any selection
			ST_RECALL: phase_d = ST_WAIT_ADC;
			ST_WAIT_ADC: begin
				if (update) begin
					phase_d = ST_RUN;
				end
			end
			ST_RUN: begin
				dac1_d = sel_q.dac1_direct_sel ? ctrl3_q : first_lookup_table_mem[row1];
				dac2_d = sel_q.dac2_direct_sel ? ctrl4_q : second_lookup_table_mem[row2];
			end
			default: phase_d = ST_RECALL;
		endcase
	end

	// bytes held at idle until the first valid result
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= ST_RECALL;
			dac1_q <= `CODE_IDLE;
			dac2_q <= `CODE_IDLE;
		end else begin
			phase_q <= phase_d;
			dac1_q <= dac1_d;
			dac2_q <= dac2_d;
		end
	end

	assign dac1_code = dac1_q;
	assign dac2_code = dac2_q;

	// ****************************************
	// Read data
	// ****************************************
	logic [31:0] rd_q;
	logic [31:0] rd_d;
	logic [7:0] rbyte;

	always_comb begin
		rbyte = 8'h00;
		case (idx)
			`IDX_CTRL0: rbyte = {5'h00, actl_q.adc_filter_disable, actl_q.adc_input_select,
				actl_q.reference_select};
			`IDX_CTRL1: rbyte = ctrl1_q;
			`IDX_CTRL2: rbyte = ctrl2_q;
			`IDX_CTRL3: rbyte = ctrl3_q;
			`IDX_CTRL4: rbyte = ctrl4_q;
			`IDX_CTRL5: rbyte = sel_q;
			`IDX_WEN: rbyte = {wel_q, 7'h00};
			`IDX_RESULT: rbyte = result_q;
			default: begin
				if (hit_first_lookup_table) begin
					rbyte = first_lookup_table_mem[first_lookup_table_off];
				end else if (hit_second_lookup_table) begin
					rbyte = second_lookup_table_mem[second_lookup_table_off];
				end
			end
		endcase
		rd_d = rd_q;
		if (setup) begin
			rd_d = {24'h000000, rbyte};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd_q <= 32'h00000000;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign prdata = rd_q;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_set_write;
		access && pwrite && idx == `IDX_WEN && wbyte == `WEN_SET;
	endsequence
	sequence s_clr_write;
		access && pwrite && idx == `IDX_WEN && wbyte == `WEN_CLR;
	endsequence

	a_blocked_write_err: assert property (@(posedge clk_sys) disable iff (!rst_b)
		access && pwrite && !wel_q && idx == `IDX_CTRL3 |-> pslverr ##1 ctrl3_q == $past(ctrl3_q))
		else $error("write taken while latch clear");

	a_latch_set_pattern: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_set_write |=> wel_q)
		else $error("latch not set by set pattern");

	a_latch_clear_pattern: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_clr_write |=> !wel_q)
		else $error("latch not cleared by zero pattern");

	a_latch_holds_value: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!(access && pwrite && idx == `IDX_WEN && (wbyte == `WEN_SET || wbyte == `WEN_CLR)) |=> $stable(wel_q))
		else $error("latch moved without pattern");

	a_result_readonly: assert property (@(posedge clk_sys) disable iff (!rst_b)
		access && pwrite && idx == `IDX_RESULT |-> pslverr)
		else $error("result register accepted a write");

	a_filter_unfiltered: assert property (@(posedge clk_sys) disable iff (!rst_b)
		conv_valid && actl_q.adc_filter_disable |=> result_q == $past(conv_data))
		else $error("unfiltered result not updated");

	a_filter_single_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		conv_valid && !actl_q.adc_filter_disable && !same |=> $stable(result_q))
		else $error("result updated on mismatching conversion");

	a_idle_until_valid: assert property (@(posedge clk_sys) disable iff (!rst_b)
		phase_q != ST_RUN |=> dac1_q == `CODE_IDLE && dac2_q == `CODE_IDLE)
		else $error("converter byte left idle too early");

	a_direct_code_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
		phase_q == ST_RUN && sel_q.dac1_direct_sel |=> dac1_q == $past(ctrl3_q))
		else $error("converter 1 direct code not used");

	a_direct_code_two: assert property (@(posedge clk_sys) disable iff (!rst_b)
		phase_q == ST_RUN && sel_q.dac2_direct_sel |=> dac2_q == $past(ctrl4_q))
		else $error("converter 2 direct code not used");

	a_manual_row_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
		phase_q == ST_RUN && !sel_q.dac1_direct_sel && sel_q.first_lookup_table_row_source_sel
		|=> dac1_q == $past(first_lookup_table_mem[ctrl1_q[5:0]]))
		else $error("table 1 manual row not used");

	a_result_row_two: assert property (@(posedge clk_sys) disable iff (!rst_b)
		phase_q == ST_RUN && !sel_q.dac2_direct_sel && !sel_q.second_lookup_table_row_source_sel
		|=> dac2_q == $past(second_lookup_table_mem[result_q[7:2]]))
		else $error("table 2 result row not used");

endmodule : lut_dac_source_select

// >>> verification/apb_host_model.sv
// APB host model that issues register transfers to the converter source selector
`timescale 1ns/1ns

module apb_host_model (
	input wire logic clk_sys,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// ****************************************
	// One transfer: setup, access until pready
	// ****************************************
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic err, output logic hung);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata[7:0];
		err = pslverr;
		hung = (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines must not keep the old value
		paddr <= ~a;
		pwdata <= ~{24'h000000, d};
	endtask : xfer
endmodule : apb_host_model

// >>> verification/testbench.sv
// Self-checking testbench of the converter source selector
`timescale 1ns/1ns
`include "lut_dac_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, (g), (e)); end end

module testbench;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic conv_valid = 1'b0;
	logic [7:0] conv_data = 8'h00;
	logic [7:0] dac1_code, dac2_code;
	logic reference_select, adc_input_select, write_enable_latch;
	logic [3:0] full_scale_sel;
	int n_errors = 0;
	int num_checks = 0;

	always #20 clk_sys = ~clk_sys;

	apb_host_model host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	lut_dac_source_select i_lut_dac_source_select (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_valid(conv_valid), .conv_data(conv_data), .dac1_code(dac1_code),
		.dac2_code(dac2_code), .reference_select(reference_select), .adc_input_select(adc_input_select),
		.full_scale_sel(full_scale_sel), .write_enable_latch(write_enable_latch));

	// ****************************************
	// Shared helpers
	// ****************************************
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	function automatic logic [7:0] l1v(input int r);
		return {r[5:0], 2'b01};
	endfunction : l1v

	function automatic logic [7:0] l2v(input int r);
		return ~{r[5:0], 2'b10};
	endfunction : l2v

	task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [7:0] rd,
		output logic err);
		logic hung;
		host.xfer(w, {idx, 2'b00}, d, rd, err, hung);
		if (hung) begin
			n_errors++;
			print_verdict();
		end
	endtask : bus

	task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic exp_err);
		logic [7:0] rd;
		logic err;
		bus(1'b1, idx, d, rd, err);
		`CHK(err, exp_err)
	endtask : wr

	task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp, input logic exp_err);
		logic [7:0] rd;
		logic err;
		bus(1'b0, idx, 8'h00, rd, err);
		`CHK(rd, exp)
		`CHK(err, exp_err)
	endtask : rd_chk

	task automatic conv(input logic [7:0] d);
		@(posedge clk_sys);
		conv_valid <= 1'b1;
		conv_data <= d;
		@(posedge clk_sys);
		conv_valid <= 1'b0;
		conv_data <= ~d;
	endtask : conv

	// Sample on falling edges so registered outputs have landed
	task automatic settle();
		repeat (3) @(negedge clk_sys);
	endtask : settle

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic sc_power_up();
		`CHK(write_enable_latch, 1'b0)
		`CHK(dac1_code, `CODE_IDLE)
		`CHK({reference_select, adc_input_select, full_scale_sel}, 6'h00)
		rd_chk(`IDX_CTRL5, `CTRL_RST, 1'b0);
		wr(`IDX_CTRL0, 8'h07, 1'b1);
		rd_chk(`IDX_CTRL0, 8'h00, 1'b0);
		wr(`IDX_WEN, `WEN_SET, 1'b0);
		wr(`IDX_WEN, 8'h01, 1'b0);
		rd_chk(`IDX_WEN, 8'h80, 1'b0);
		`CHK(write_enable_latch, 1'b1)
	endtask : sc_power_up

	task automatic sc_filter();
		for (int r = 0; r < 64; r++) begin
			wr(10'(`IDX_FIRST_LOOKUP_TABLE_BASE + r), l1v(r), 1'b0);
			wr(10'(`IDX_SECOND_LOOKUP_TABLE_BASE + r), l2v(r), 1'b0);
		end
		rd_chk(10'(`IDX_SECOND_LOOKUP_TABLE_BASE + 7), l2v(7), 1'b0);
		rd_chk(10'(`IDX_FIRST_LOOKUP_TABLE_BASE + 63), l1v(63), 1'b0);
		wr(`IDX_CTRL0, 8'h03, 1'b0);
		settle();
		`CHK({reference_select, adc_input_select}, 2'b11)
		// A broken run must restart the count
		conv(8'h15);
		conv(8'h16);
		conv(8'h17);
		conv(8'h40);
		conv(8'h15);
		conv(8'h14);
		conv(8'h17);
		settle();
		`CHK(dac1_code, `CODE_IDLE)
		conv(8'h16);
		settle();
		rd_chk(`IDX_RESULT, 8'h16, 1'b0);
		`CHK(dac1_code, l1v(5))
		`CHK(dac2_code, l2v(5))
		conv(8'h17);
		wr(`IDX_RESULT, 8'h33, 1'b1);
		rd_chk(`IDX_RESULT, 8'h17, 1'b0);
		wr(`IDX_CTRL0, 8'h04, 1'b0);
		conv(8'hFF);
		settle();
		rd_chk(`IDX_RESULT, 8'hFF, 1'b0);
		`CHK(dac1_code, l1v(63))
		conv(8'h00);
		settle();
		rd_chk(`IDX_RESULT, 8'h00, 1'b0);
		`CHK(dac2_code, l2v(0))
		`CHK({reference_select, adc_input_select}, 2'b00)
	endtask : sc_filter

	task automatic sc_manual();
		wr(`IDX_CTRL1, 8'hC3, 1'b0);
		wr(`IDX_CTRL2, 8'h3C, 1'b0);
		wr(`IDX_CTRL5, 8'h5A, 1'b0);
		settle();
		`CHK(dac1_code, l1v(3))
		`CHK(dac2_code, l2v(60))
		`CHK(full_scale_sel, 4'hA)
		wr(`IDX_CTRL3, 8'hA5, 1'b0);
		wr(`IDX_CTRL4, 8'h3C, 1'b0);
		wr(`IDX_CTRL5, 8'hA0, 1'b0);
		settle();
		`CHK(dac1_code, 8'hA5)
		`CHK(dac2_code, 8'h3C)
	endtask : sc_manual

	task automatic sc_lock();
		wr(`IDX_WEN, `WEN_CLR, 1'b0);
		wr(`IDX_CTRL3, 8'h11, 1'b1);
		settle();
		`CHK(write_enable_latch, 1'b0)
		`CHK(dac1_code, 8'hA5)
		rd_chk(`IDX_CTRL3, 8'hA5, 1'b0);
		rd_chk(10'h088, 8'h00, 1'b1);
		wr(`IDX_WEN, `WEN_SET, 1'b0);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		settle();
		`CHK(write_enable_latch, 1'b0)
		`CHK(dac2_code, `CODE_IDLE)
		`CHK(full_scale_sel, 4'h0)
	endtask : sc_lock

	initial begin
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		settle();
		sc_power_up();
		sc_filter();
		sc_manual();
		sc_lock();
		print_verdict();
	end
endmodule : testbench
